// ===== logic/jack_detect_defs.svh
// Holds the constants of the jack-detect and slow-timer block.
// Assumes inclusion by bare name from the design package and module.
`ifndef JACK_DETECT_DEFS_SVH
`define JACK_DETECT_DEFS_SVH

`define JD_ADDR_CTRL 4'h0
`define JD_ADDR_GPIO 4'h1
`define JD_ADDR_JACK 4'h2
`define JD_ADDR_MASK 4'h3
`define JD_ADDR_STAT 4'h4
`define JD_ADDR_IRQM 4'h5
`define JD_ADDR_OUTS 4'h6
`define JD_ADDR_ZCTO 4'h7

// Control word fields.
`define JD_CTRL_TIMER_EN 0
`define JD_CTRL_RATE_LSB 1
`define JD_CTRL_BIAS_EN 4
`define JD_CTRL_LOUT_L 5
`define JD_CTRL_LOUT_R 6
// Jack config fields.
`define JD_JACK_EN 0
`define JD_JACK_SEL_LSB 1
`define JD_JACK_BIAS 3
// Status bits.
`define JD_STAT_TICK 0
`define JD_STAT_JACK 1
`define JD_STAT_ZCTO 2

`define JD_TICK_MS 128
`define JD_CLK_KHZ 100000
// Full-rate divider for 128 ms at 100 MHz; other rates scale it.
`define JD_TICK_CYCLES (`JD_TICK_MS * `JD_CLK_KHZ)
// Half-period marks that a change must survive before the level flips.
`define JD_DEB_TICKS 3'h6
`define JD_ZERO32 32'h0000_0000
`define JD_ZERO8 8'h00
`define JD_ZERO3 3'h0
`define JD_ZERO2 2'h0

`endif

// ===== logic/jack_detect_pkg.sv
// Holds the types of the jack-detect and slow-timer block.
// Assumes the constants header is on the include path.
`include "jack_detect_defs.svh"
package jack_detect_pkg;
  typedef enum logic [2:0] {
    DEB_IDLE = 3'b001,
    DEB_WAIT = 3'b010,
    DEB_DONE = 3'b100
  } deb_state_t;
endpackage : jack_detect_pkg

// ===== logic/jack_detect_slow_timer.sv
// Slow timer tick generator, jack-sense debouncer and jack-linked enables.
// Assumes one 100 MHz clock, a plain register port and asynchronous pins.
// Contract
// RQ1: Slow timer is disabled after reset and runs only once software enables it.
// RQ2: Tick comes from an integer clock divider chosen by indicated sample rate, 128 ms.
// RQ3: Tick period scales with the ratio of actual to indicated sample rate.
// RQ4: Software enables the timer whenever debounce or holdoff timeout is used.
// RQ5: Optional slow-timer timeout ends a pending zero-crossing volume holdoff.
// RQ6: Pin a may be input or output; pins b and c are inputs only.
// RQ7: Exactly one of three pins feeds jack detect, chosen by a field.
// RQ8: Jack detect has enable, pin select and a bias-enable option.
// RQ9: Debounced level changes after 2.5 to 3.5 ticks of steady change.
// RQ10: Bias generator enable is debounced jack OR the software bias bit.
// RQ11: Each line output enable is its power bit AND jack-derived enable.
// RQ12: Two output masks: one for jack level 1, one for jack level 0.
// RQ13: Software disconnects a line input's analog path when used as logic.
// RQ14: The jack-sense pins pass a two-stage synchroniser before the debouncer.
`include "jack_detect_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module jack_detect_slow_timer
#(
  parameter int unsigned TICK_CYCLES = `JD_TICK_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic multi_io_pin_a_i,
  input wire logic sense_in_pin_b_i,
  input wire logic sense_in_pin_c_i,
  output logic multi_io_pin_a_o,
  output logic multi_io_pin_a_oe_o,
  input wire logic zc_holdoff_pending_i,
  output logic zc_timeout_o,
  output logic jack_level_o,
  output logic bias_gen_enable_o,
  output logic line_out_left_en_o,
  output logic line_out_right_en_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] ctrl;
  logic [7:0] gpio_cfg;
  logic [7:0] jack_cfg;
  logic [7:0] out_mask;
  logic [2:0] status;
  logic [2:0] irq_mask;
  logic [3:0] zc_limit;

  wire wr_ctrl = wr_i && (addr_i == `JD_ADDR_CTRL);
  wire wr_gpio = wr_i && (addr_i == `JD_ADDR_GPIO);
  wire wr_jack = wr_i && (addr_i == `JD_ADDR_JACK);
  wire wr_mask = wr_i && (addr_i == `JD_ADDR_MASK);
  wire wr_stat = wr_i && (addr_i == `JD_ADDR_STAT);
  wire wr_irqm = wr_i && (addr_i == `JD_ADDR_IRQM);
  wire wr_zcto = wr_i && (addr_i == `JD_ADDR_ZCTO);

  wire timer_en = ctrl[`JD_CTRL_TIMER_EN];
  wire [2:0] rate_sel = ctrl[`JD_CTRL_RATE_LSB +: 3];
  wire jack_en = jack_cfg[`JD_JACK_EN];
  wire [1:0] jack_sel = jack_cfg[`JD_JACK_SEL_LSB +: 2];
  wire jack_bias = jack_cfg[`JD_JACK_BIAS];
  wire jack_on_a = jack_en && (jack_sel == `JD_ZERO2 || jack_sel == 2'h3);
  wire [2:0] next_irq_mask = wr_irqm ? wdata_i[2:0] : irq_mask;

  // Reset leaves the timer disabled; it runs only after software sets the bit.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= `JD_ZERO8; // see RQ1
      gpio_cfg <= `JD_ZERO8;
      jack_cfg <= `JD_ZERO8;
      out_mask <= `JD_ZERO8;
      irq_mask <= `JD_ZERO3;
      zc_limit <= 4'h0;
    end
    else
    begin
      if (wr_ctrl) ctrl <= wdata_i;
      if (wr_gpio) gpio_cfg <= wdata_i;
      if (wr_jack) jack_cfg <= wdata_i; // see RQ8
      if (wr_mask) out_mask <= wdata_i; // see RQ12
      if (wr_irqm) irq_mask <= wdata_i[2:0];
      if (wr_zcto) zc_limit <= wdata_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow timer.

  // Divider per indicated rate: 48k, 32k, 24k, 16k, 12k, 8k; rate is fixed
  // by the clock, so a wrong indication stretches the tick proportionally.
  function automatic logic [31:0] tick_div(input logic [2:0] sel);
    case (sel)
      3'h1: tick_div = 32'(TICK_CYCLES * 3 / 2);
      3'h2: tick_div = 32'(TICK_CYCLES * 2);
      3'h3: tick_div = 32'(TICK_CYCLES * 3);
      3'h4: tick_div = 32'(TICK_CYCLES * 4);
      3'h5: tick_div = 32'(TICK_CYCLES * 6);
      default: tick_div = 32'(TICK_CYCLES);
    endcase
  endfunction : tick_div

  logic [31:0] div_cnt;
  logic tick;
  logic half_tick;
  wire [31:0] div_top = tick_div(rate_sel) - 32'h0000_0001; // see RQ2
  wire div_wrap = (div_cnt >= div_top); // see RQ3
  wire [31:0] div_mid = div_top >> 1;
  wire div_half = (div_cnt == div_mid);
  wire [31:0] next_div_cnt = div_wrap ? `JD_ZERO32 : div_cnt + 32'h0000_0001;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt <= `JD_ZERO32;
      tick <= 1'b0;
      half_tick <= 1'b0;
    end
    else
    begin
      div_cnt <= timer_en ? next_div_cnt : `JD_ZERO32; // see RQ1
      tick <= timer_en && div_wrap; // see RQ2
      half_tick <= timer_en && (div_wrap || div_half); // see RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and synchronisers.

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // Only pin a can drive; b and c have no output path at all.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta <= `JD_ZERO3;
      pin_sync <= `JD_ZERO3;
      multi_io_pin_a_o <= 1'b0;
      multi_io_pin_a_oe_o <= 1'b0;
    end
    else
    begin
      pin_meta <= {sense_in_pin_c_i, sense_in_pin_b_i, multi_io_pin_a_i}; // see RQ14
      pin_sync <= pin_meta; // see RQ14
      multi_io_pin_a_oe_o <= gpio_cfg[0] && !jack_on_a; // see RQ6
      multi_io_pin_a_o <= gpio_cfg[1]; // see RQ6
    end
  end

  // Selection 3 is treated as pin a so exactly one source is ever chosen.
  wire jack_raw = (jack_sel == 2'h1) ? pin_sync[1] :
                  (jack_sel == 2'h2) ? pin_sync[2] : pin_sync[0]; // see RQ7

  ////////////////////////////////////////////////////////////////////////////
  // Debouncer: a change must stay through six half-period marks of the slow
  // timer. The first mark falls within half a period of the change, so a steady
  // change flips the level after 2.5 to 3 periods; any gap starts over.

  jack_detect_pkg::deb_state_t deb_state;
  jack_detect_pkg::deb_state_t next_deb_state;
  logic [2:0] deb_cnt;
  logic jack_level;
  wire differs = jack_en && (jack_raw != jack_level);

  always_comb
  begin
    next_deb_state = deb_state;
    case (deb_state)
      jack_detect_pkg::DEB_IDLE:
        if (differs) next_deb_state = jack_detect_pkg::DEB_WAIT;
      jack_detect_pkg::DEB_WAIT:
        if (!differs) next_deb_state = jack_detect_pkg::DEB_IDLE; // see RQ9
        else if (half_tick && deb_cnt == `JD_DEB_TICKS - 3'h1)
          next_deb_state = jack_detect_pkg::DEB_DONE;
      jack_detect_pkg::DEB_DONE: next_deb_state = jack_detect_pkg::DEB_IDLE;
      default: next_deb_state = jack_detect_pkg::DEB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      deb_state <= jack_detect_pkg::DEB_IDLE;
      deb_cnt <= `JD_ZERO3;
      jack_level <= 1'b0;
    end
    else
    begin
      deb_state <= next_deb_state;
      if (deb_state != jack_detect_pkg::DEB_WAIT || !differs) deb_cnt <= `JD_ZERO3;
      else if (half_tick) deb_cnt <= deb_cnt + 3'h1; // see RQ9
      if (deb_state == jack_detect_pkg::DEB_DONE) jack_level <= ~jack_level; // see RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-crossing holdoff timeout, counted in slow ticks; zero disables it.

  logic [3:0] zc_cnt;
  wire zc_expire = zc_holdoff_pending_i && zc_limit != 4'h0 && tick
                   && zc_cnt == zc_limit - 4'h1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      zc_cnt <= 4'h0;
      zc_timeout_o <= 1'b0;
    end
    else
    begin
      if (!zc_holdoff_pending_i || zc_expire) zc_cnt <= 4'h0;
      else if (tick) zc_cnt <= zc_cnt + 4'h1; // see RQ5
      zc_timeout_o <= zc_expire; // see RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Linked enables, status and read-back.

  // Mask low nibble applies at jack level 1, high nibble at level 0.
  wire [1:0] jack_outs = !jack_en ? 2'h3 : jack_level ? out_mask[1:0] : out_mask[5:4]; // see RQ12
  wire jack_edge = deb_state == jack_detect_pkg::DEB_DONE;
  wire [2:0] events = {zc_expire, jack_edge, tick};
  wire [2:0] next_status = events | (status & ~(wr_stat ? wdata_i[2:0] : `JD_ZERO3));

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status <= `JD_ZERO3;
      irq_o <= 1'b0;
      jack_level_o <= 1'b0;
      bias_gen_enable_o <= 1'b0;
      line_out_left_en_o <= 1'b0;
      line_out_right_en_o <= 1'b0;
      rdata_o <= `JD_ZERO8;
    end
    else
    begin
      status <= next_status;
      irq_o <= |(next_status & next_irq_mask);
      jack_level_o <= jack_level;
      bias_gen_enable_o <= ctrl[`JD_CTRL_BIAS_EN] || (jack_bias && jack_level); // see RQ10
      line_out_left_en_o <= ctrl[`JD_CTRL_LOUT_L] && jack_outs[0]; // see RQ11
      line_out_right_en_o <= ctrl[`JD_CTRL_LOUT_R] && jack_outs[1]; // see RQ11
      if (!rd_i) rdata_o <= `JD_ZERO8;
      else
        case (addr_i)
          `JD_ADDR_CTRL: rdata_o <= ctrl;
          `JD_ADDR_GPIO: rdata_o <= gpio_cfg;
          `JD_ADDR_JACK: rdata_o <= jack_cfg;
          `JD_ADDR_MASK: rdata_o <= out_mask;
          `JD_ADDR_STAT: rdata_o <= {5'h00, status};
          `JD_ADDR_IRQM: rdata_o <= {5'h00, irq_mask};
          `JD_ADDR_OUTS: rdata_o <= {4'h0, pin_sync, jack_level};
          `JD_ADDR_ZCTO: rdata_o <= {4'h0, zc_limit};
          default: rdata_o <= `JD_ZERO8;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_timer_off_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ1
    !timer_en |=> !tick) else $error("tick while timer disabled");

  a_bias_or_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ10
    (ctrl[`JD_CTRL_BIAS_EN] || (jack_bias && jack_level)) |=> bias_gen_enable_o)
    else $error("bias enable missing");

  a_line_and_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ11
    !ctrl[`JD_CTRL_LOUT_L] |=> !line_out_left_en_o) else $error("left out on without power bit");

  a_right_and_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ11
    !ctrl[`JD_CTRL_LOUT_R] |=> !line_out_right_en_o) else $error("right out on without power bit");

  a_jack_needs_ticks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ9
    (deb_state == jack_detect_pkg::DEB_DONE) |-> $past(deb_cnt) == `JD_DEB_TICKS - 3'h1)
    else $error("jack changed too early");

  a_pin_a_only_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ6
    jack_on_a |=> !multi_io_pin_a_oe_o) else $error("pin a driven as sense");

  a_zc_after_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ5
    zc_timeout_o |-> $past(tick) && $past(zc_holdoff_pending_i)) else $error("timeout without tick");

  a_tick_single: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ2
    tick |=> !tick) else $error("tick longer than one cycle");

  a_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (|(status & irq_mask)) |-> irq_o) else $error("irq not raised");

endmodule : jack_detect_slow_timer

`default_nettype wire

// ===== testbench/jack_switch.sv
// Model of the mechanical jack sense switch that sits on a sense pin.
// Assumes the bench clock and a plug level that the bench drives.
`timescale 1ns/1ps
`default_nettype none

module jack_switch
(
  input wire logic clk_sys_i,
  input wire logic plug_i,
  output logic sense_o
);
  logic last = 1'b0;
  logic [2:0] bounce = 3'h0;
  // Contacts chatter for a few cycles after each plug change, as a real switch does.
  always @(posedge clk_sys_i)
  begin
    if (plug_i !== last)
      bounce <= 3'h5;
    else if (bounce != 3'h0)
      bounce <= bounce - 3'h1;
    last <= plug_i;
  end
  assign sense_o = (bounce != 3'h0) ? bounce[0] : plug_i;
endmodule : jack_switch

`default_nettype wire

// ===== testbench/tb_top.sv
// Register-level bench of the jack-detect and slow-timer block.
// Assumes the block's register port and one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pin_a = 1'b0;
  logic pin_c = 1'b0;
  logic plug = 1'b0;
  logic zc_pend = 1'b0;
  logic [7:0] rdata_o;
  logic sense_b, pa_o, pa_oe, zc_to, jack_lvl, bias, lo_l, lo_r, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_lo;
  int n_hi;
  // A short tick keeps debounce and timeout runs within a few thousand cycles.
  localparam int TICK = 40;
  logic [7:0] c_ctl [5] = '{8'h70, 8'h60, 8'h60, 8'h20, 8'h20};
  logic [7:0] c_jack [5] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h09};
  logic [7:0] c_mask [5] = '{8'h00, 8'h10, 8'h23, 8'h30, 8'h30};
  logic [7:0] c_exp [5] = '{8'h07, 8'h04, 8'h02, 8'h04, 8'h04};

  always #5 clk_sys_i = ~clk_sys_i;

  jack_switch i_jack_switch (.clk_sys_i(clk_sys_i), .plug_i(plug), .sense_o(sense_b));

  jack_detect_slow_timer #(.TICK_CYCLES(TICK)) i_jack_detect_slow_timer
  (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .multi_io_pin_a_i(pin_a),
    .sense_in_pin_b_i(sense_b), .sense_in_pin_c_i(pin_c), .multi_io_pin_a_o(pa_o),
    .multi_io_pin_a_oe_o(pa_oe), .zc_holdoff_pending_i(zc_pend), .zc_timeout_o(zc_to),
    .jack_level_o(jack_lvl), .bias_gen_enable_o(bias), .line_out_left_en_o(lo_l),
    .line_out_right_en_o(lo_r), .irq_o(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Waits for a watched output to reach a level; a miss counts and ends the run.
  task automatic wait_for(input int which, input logic lvl, output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1 n = n + 1;
    end
    while (((which == 0) ? zc_to : jack_lvl) !== lvl && n < 1000);
    if (((which == 0) ? zc_to : jack_lvl) !== lvl)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : wait_for

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd

  task automatic stop_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch and still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 9; a++)
      rd(a[3:0], 8'h00);
    wr(4'h1, 8'h03);
    repeat (2) @(posedge clk_sys_i);
    chk({6'h00, pa_oe, pa_o}, 8'h03);
    wr(4'h1, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk({6'h00, pa_oe, pa_o}, 8'h02);
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h0, c_ctl[i]);
      wr(4'h2, c_jack[i]);
      wr(4'h3, c_mask[i]);
      repeat (3) @(posedge clk_sys_i);
      chk({5'h00, lo_l, lo_r, bias}, c_exp[i]);
      rd(4'h3, c_mask[i]);
    end
    @(posedge clk_sys_i);
    pin_a <= 1'b1;
    plug <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rd(4'h6, 8'h06);
    chk({7'h00, jack_lvl}, 8'h00);
    wr(4'h5, 8'h07);
    wr(4'h4, 8'h07);
    rd(4'h4, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(4'h7, 8'h01);
    @(posedge clk_sys_i);
    zc_pend <= 1'b1;
    wr(4'h0, 8'h0B);
    repeat (20) @(posedge clk_sys_i);
    chk({7'h00, zc_to}, 8'h00);
    rd(4'h0, 8'h0B);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    wait_for(0, 1'b1, n_lo);
    wait_for(0, 1'b0, n_lo);
    wait_for(0, 1'b1, n_hi);
    chk_rng(n_lo + n_hi, 6 * TICK, 6 * TICK);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk_sys_i);
    zc_pend <= 1'b0;
    wr(4'h0, 8'h01);
    wr(4'h2, 8'h0B);
    repeat (200) @(posedge clk_sys_i);
    chk({7'h00, jack_lvl}, 8'h01);
    wr(4'h0, 8'h61);
    wr(4'h3, 8'h21);
    wr(4'h5, 8'h02);
    wr(4'h4, 8'h07);
    repeat (2) @(posedge clk_sys_i);
    chk({5'h00, lo_l, lo_r, bias}, 8'h05);
    chk({7'h00, irq}, 8'h00);
    plug <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    plug <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    chk({6'h00, jack_lvl, irq}, 8'h02);
    plug <= 1'b0;
    wait_for(1, 1'b0, n_lo);
    chk_rng(n_lo, 5 * TICK / 2, 7 * TICK / 2 + 10);
    repeat (2) @(posedge clk_sys_i);
    chk({5'h00, lo_l, lo_r, bias}, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(4'h4, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    chk({7'h00, irq}, 8'h00);
    wr(4'h2, 8'h05);
    repeat (200) @(posedge clk_sys_i);
    chk({7'h00, jack_lvl}, 8'h00);
    pin_c <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    chk({7'h00, jack_lvl}, 8'h01);
    wr(4'h2, 8'h07);
    repeat (2) @(posedge clk_sys_i);
    chk({6'h00, pa_oe, pa_o}, 8'h00);
    // The analog path of a sense pin is left to software and is not modelled.
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
